// *** include/pie_pkg.sv ***
package pie_pkg;

    localparam int NUM_GROUPS  = 12;
    localparam int GROUP_W     = 8;
    localparam int NUM_POS     = 96;
    localparam int POS_IDX_W   = 7;
    localparam int WORD_W      = 16;
    localparam int VEC_W       = 32;
    localparam int LINE_W      = 4;
    localparam int POS_W       = 3;
    localparam int ADDR_W      = 16;

    // vector table placement, in cpu word addresses
    localparam logic [ADDR_W-1:0] VEC_BASE = 16'h0D40;
    localparam logic [ADDR_W-1:0] VEC_LAST = 16'h0DFE;
    localparam logic [ADDR_W-1:0] VEC_END  = 16'h0DFF;
    localparam int POS_WORDS   = 2;
    localparam int GROUP_WORDS = 16;

    // bound on vector fetch and context save, cpu cycles
    localparam int FETCH_MAX_CYC = 8;

    localparam logic [LINE_W-1:0] LINE_MIN = 4'h1;
    localparam logic [LINE_W-1:0] LINE_MAX = 4'hC;

    // bit g*8+p is group g+1 position p+1; zero marks reserved
    localparam logic [NUM_POS-1:0] WIRED_MASK =
        96'hFB_0F_FF_03_03_FF_F3_C7_FF_FF_FF_DB;

    localparam int DMA_CH      = 6;
    localparam int ADC_EV      = 8;
    localparam int IPC_IRQ     = 4;
    localparam int DMA_BASE    = 48;
    localparam int ADC_BASE    = 72;
    localparam int IPC_BASE    = 80;
    localparam int FPU_OVF_POS = 94;
    localparam int FPU_UNF_POS = 95;

    typedef struct packed {
        logic                valid;
        logic [LINE_W-1:0]   line;
        logic [GROUP_W-1:0]  data;
    } pie_grp_wr_s;

    typedef struct packed {
        logic                valid;
        logic [ADDR_W-1:0]   addr;
        logic [WORD_W-1:0]   data;
    } pie_vec_wr_s;

    typedef struct packed {
        logic                valid;
        logic [LINE_W-1:0]   line;
    } pie_ack_s;

    typedef struct packed {
        logic                valid;
        logic                hit;
        logic [LINE_W-1:0]   line;
        logic [POS_W-1:0]    pos;
        logic [VEC_W-1:0]    vector;
    } pie_vec_s;

    typedef enum logic [1:0] {
        PIE_IDLE,
        PIE_SELECT,
        PIE_ANSWER
    } pie_state_e;

    function automatic logic line_ok(input logic [LINE_W-1:0] line);
        return (line >= LINE_MIN) && (line <= LINE_MAX);
    endfunction

    function automatic logic [NUM_GROUPS-1:0] grp_onehot(
        input logic [LINE_W-1:0] line);
        logic [NUM_GROUPS-1:0] r;
        r = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            if (line_ok(line) && (line - LINE_MIN) == g[LINE_W-1:0]) begin
                r[g] = 1'b1;
            end
        end
        return r;
    endfunction

    // lowest set position wins
    function automatic logic [POS_W-1:0] first_set(
        input logic [GROUP_W-1:0] v);
        logic [POS_W-1:0] r;
        r = '0;
        for (int i = GROUP_W - 1; i >= 0; i--) begin
            if (v[i]) begin
                r = i[POS_W-1:0];
            end
        end
        return r;
    endfunction

endpackage

// *** rtl/pie_expander.sv ***
`timescale 1ns/1ps
module pie_expander (
    input  wire logic                                core_clk,
    input  wire logic                                rst_n,
    input  wire logic [pie_pkg::NUM_POS-1:0]         periph_src,
    input  wire logic [pie_pkg::DMA_CH-1:0]          dma_channel_irq,
    input  wire logic [pie_pkg::ADC_EV-1:0]          adc_event,
    input  wire logic [pie_pkg::IPC_IRQ-1:0]         interprocessor_irq,
    input  wire logic                                fpu_overflow_event,
    input  wire logic                                fpu_underflow_event,
    input  wire logic                                timer_one_irq,
    input  wire logic                                timer_two_irq,
    input  wire logic                                direct_nmi_request,
    input  wire pie_pkg::pie_grp_wr_s                flag_wr,
    input  wire pie_pkg::pie_grp_wr_s                enable_wr,
    input  wire pie_pkg::pie_vec_wr_s                vec_wr,
    input  wire pie_pkg::pie_ack_s                   cpu_ack,
    input  wire logic [pie_pkg::LINE_W-1:0]          rd_line,
    output logic      [pie_pkg::NUM_GROUPS-1:0]      cpu_group_lines,
    output pie_pkg::pie_vec_s                        cpu_vec,
    output logic      [pie_pkg::GROUP_W-1:0]         rd_flag,
    output logic      [pie_pkg::GROUP_W-1:0]         rd_enable,
    output logic                                     timer_one_line,
    output logic                                     timer_two_line,
    output logic                                     nmi_line
);
    import pie_pkg::*;

    localparam int FETCH_BOUND = FETCH_MAX_CYC;

    logic [NUM_POS-1:0]     src;
    logic [NUM_POS-1:0]     flags;
    logic [NUM_POS-1:0]     enables;
    logic [GROUP_W-1:0]     pend_arr [NUM_GROUPS];
    logic [GROUP_W-1:0]     clr_arr  [NUM_GROUPS];
    logic [NUM_GROUPS-1:0]  flag_sel;
    logic [NUM_GROUPS-1:0]  en_sel;
    logic [NUM_GROUPS-1:0]  ack_sel;
    logic [NUM_GROUPS-1:0]  next_lines;
    logic [NUM_GROUPS-1:0]  rd_sel;
    pie_state_e             state;
    pie_state_e             next_state;
    logic [LINE_W-1:0]      ack_line;
    logic [GROUP_W-1:0]     sel_pend;
    logic [POS_W-1:0]       sel_pos;
    logic                   sel_hit;
    logic                   vec_in_range;
    logic [ADDR_W-1:0]      vec_off;
    logic [POS_IDX_W-1:0]   vec_wr_idx;
    logic [VEC_W-1:0]       ram_rd;
    logic [GROUP_W-1:0]     next_rd_flag;
    logic [GROUP_W-1:0]     next_rd_enable;

    // reserved positions see no hardware, only software writes
    always_comb begin
        src = periph_src & WIRED_MASK;
        src[DMA_BASE +: DMA_CH] = dma_channel_irq;
        src[ADC_BASE +: ADC_EV] = adc_event;
        src[IPC_BASE +: IPC_IRQ] = interprocessor_irq;
        src[FPU_OVF_POS] = fpu_overflow_event;
        src[FPU_UNF_POS] = fpu_underflow_event;
    end

    assign flag_sel = grp_onehot(flag_wr.line);
    assign en_sel   = grp_onehot(enable_wr.line);
    assign ack_sel  = grp_onehot(ack_line);
    assign rd_sel   = grp_onehot(rd_line);

    generate
        for (genvar g = 0; g < NUM_GROUPS; g++) begin : grp
            always_comb begin
                clr_arr[g] = '0;
                if (state == PIE_SELECT && ack_sel[g] && sel_hit) begin
                    clr_arr[g][sel_pos] = 1'b1;
                end
            end

            pie_group #(
                .W(GROUP_W)
            ) u_group (
                .core_clk  (core_clk),
                .rst_n     (rst_n),
                .hw_set    (src[g*GROUP_W +: GROUP_W]),
                .flag_wr   (flag_wr.valid && flag_sel[g]),
                .flag_data (flag_wr.data),
                .en_wr     (enable_wr.valid && en_sel[g]),
                .en_data   (enable_wr.data),
                .ack_clr   (clr_arr[g]),
                .flag      (flags[g*GROUP_W +: GROUP_W]),
                .enable    (enables[g*GROUP_W +: GROUP_W]),
                .pend      (pend_arr[g])
            );
        end
    endgenerate

    always_comb begin
        next_lines     = '0;
        sel_pend       = '0;
        next_rd_flag   = '0;
        next_rd_enable = '0;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            next_lines[g] = |pend_arr[g];
            if (ack_sel[g]) begin
                sel_pend = pend_arr[g];
            end
            if (rd_sel[g]) begin
                next_rd_flag   = flags[g*GROUP_W +: GROUP_W];
                next_rd_enable = enables[g*GROUP_W +: GROUP_W];
            end
        end
    end

    // lowest enabled pending position of the acked group
    assign sel_hit = |sel_pend;
    assign sel_pos = first_set(sel_pend);

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_group_lines <= '0;
        end else begin
            cpu_group_lines <= next_lines;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_flag   <= '0;
            rd_enable <= '0;
        end else begin
            rd_flag   <= next_rd_flag;
            rd_enable <= next_rd_enable;
        end
    end

    // one flop only, so the dedicated lines stay fast
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            timer_one_line <= 1'b0;
            timer_two_line <= 1'b0;
            nmi_line       <= 1'b0;
        end else begin
            timer_one_line <= timer_one_irq;
            timer_two_line <= timer_two_irq;
            nmi_line       <= direct_nmi_request;
        end
    end

    // word address to entry: two words per position, sixteen per group
    assign vec_in_range = (vec_wr.addr >= VEC_BASE) &&
                          (vec_wr.addr <= VEC_END);
    assign vec_off      = vec_wr.addr - VEC_BASE;
    assign vec_wr_idx   = vec_off[POS_IDX_W:1];

    pie_vector_ram #(
        .DEPTH(NUM_POS),
        .AW   (POS_IDX_W),
        .WW   (WORD_W)
    ) u_ram (
        .core_clk (core_clk),
        .rst_n    (rst_n),
        .wr_en    (vec_wr.valid && vec_in_range),
        .wr_idx   (vec_wr_idx),
        .wr_hi    (vec_off[0]),
        .wr_data  (vec_wr.data),
        .rd_en    (state == PIE_SELECT),
        .rd_idx   ({ack_line - LINE_MIN, sel_pos}),
        .rd_data  (ram_rd)
    );

    always_comb begin
        next_state = state;
        case (state)
            PIE_IDLE: begin
                if (cpu_ack.valid && line_ok(cpu_ack.line)) begin
                    next_state = PIE_SELECT;
                end
            end
            PIE_SELECT: begin
                next_state = PIE_ANSWER;
            end
            PIE_ANSWER: begin
                next_state = PIE_IDLE;
            end
            default: begin
                next_state = PIE_IDLE;
            end
        endcase
    end

    // acks arriving while busy are dropped; cpu waits for the answer
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= PIE_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            ack_line <= '0;
        end else if (state == PIE_IDLE && cpu_ack.valid) begin
            ack_line <= cpu_ack.line;
        end
    end

    logic             hit_q;
    logic [POS_W-1:0] pos_q;

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            hit_q <= 1'b0;
            pos_q <= '0;
        end else if (state == PIE_SELECT) begin
            hit_q <= sel_hit;
            pos_q <= sel_pos;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            cpu_vec <= '0;
        end else if (state == PIE_ANSWER) begin
            cpu_vec.valid  <= 1'b1;
            cpu_vec.hit    <= hit_q;
            cpu_vec.line   <= ack_line;
            cpu_vec.pos    <= pos_q;
            cpu_vec.vector <= hit_q ? ram_rd : '0;
        end else begin
            cpu_vec.valid  <= 1'b0;
        end
    end

    a_line_tracks_pend: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        cpu_group_lines[0] == $past(|(flags[7:0] & enables[7:0])))
        else $error("line one does not follow its pending set");

    a_fetch_bound: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == PIE_IDLE && cpu_ack.valid && line_ok(cpu_ack.line))
        |-> ##[1:FETCH_BOUND] cpu_vec.valid)
        else $error("vector not supplied within eight cycles");

    a_disabled_silent: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (enables == '0) |=> (cpu_group_lines == '0))
        else $error("line raised with every position disabled");

    a_reserved_only_sw: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        ((flags & ~WIRED_MASK & ~$past(flags)) != '0)
        |-> $past(flag_wr.valid))
        else $error("reserved flag rose without a software write");

    a_sw_sets_reserved: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        (flag_wr.valid && flag_wr.line == LINE_MAX && flag_wr.data[2]
         && state != PIE_SELECT) |=> flags[FPU_OVF_POS - 4])
        else $error("software write failed to set reserved flag");

    a_direct_bypass: assert property (@(posedge core_clk)
        disable iff (!rst_n)
        timer_one_irq ##1 direct_nmi_request |-> timer_one_line
        ##1 nmi_line)
        else $error("direct line not forwarded in one cycle");

    a_fpu_map: assert property (@(posedge core_clk) disable iff (!rst_n)
        fpu_underflow_event |=> flags[FPU_UNF_POS])
        else $error("fpu underflow not on group twelve position eight");

    a_dma_map: assert property (@(posedge core_clk) disable iff (!rst_n)
        dma_channel_irq[0] && adc_event[7] |=>
        flags[DMA_BASE] && flags[ADC_BASE + ADC_EV - 1])
        else $error("dma or adc source landed on wrong position");

    a_prio_first: assert property (@(posedge core_clk) disable iff (!rst_n)
        (state == PIE_SELECT && sel_pend[0]) |=> ##1
        (cpu_vec.valid && cpu_vec.hit && cpu_vec.pos == '0))
        else $error("position one not chosen first");

    a_flags_held: assert property (@(posedge core_clk) disable iff (!rst_n)
        !$past(flag_wr.valid) && $past(state) != PIE_SELECT
        |-> ((flags & $past(flags)) == $past(flags)))
        else $error("pending flag dropped without clear");

    a_vec_layout: assert property (@(posedge core_clk) disable iff (!rst_n)
        (vec_wr.valid && vec_wr.addr == VEC_LAST)
        |-> (vec_wr_idx == POS_IDX_W'(NUM_POS - 1)) && !vec_off[0])
        else $error("last vector word maps to wrong entry");

    c_ack_hit: cover property (@(posedge core_clk) disable iff (!rst_n)
        cpu_vec.valid && cpu_vec.hit);
    c_ack_miss: cover property (@(posedge core_clk) disable iff (!rst_n)
        cpu_vec.valid && !cpu_vec.hit);
    c_sw_irq: cover property (@(posedge core_clk) disable iff (!rst_n)
        (flags & ~WIRED_MASK & enables) != '0);
    c_full_group: cover property (@(posedge core_clk) disable iff (!rst_n)
        &pend_arr[0]);
endmodule

// *** rtl/pie_group.sv ***
`timescale 1ns/1ps
module pie_group #(
    parameter int W = 8
) (
    input  wire logic         core_clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] hw_set,
    input  wire logic         flag_wr,
    input  wire logic [W-1:0] flag_data,
    input  wire logic         en_wr,
    input  wire logic [W-1:0] en_data,
    input  wire logic [W-1:0] ack_clr,
    output logic      [W-1:0] flag,
    output logic      [W-1:0] enable,
    output logic      [W-1:0] pend
);
    logic [W-1:0] next_flag;

    // hardware set beats a software write or an ack clear
    always_comb begin
        next_flag = ((flag_wr ? flag_data : flag) & ~ack_clr)
                    | hw_set;
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            flag <= '0;
        end else begin
            flag <= next_flag;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            enable <= '0;
        end else if (en_wr) begin
            enable <= en_data;
        end
    end

    assign pend = flag & enable;

    a_set_wins: assert property (@(posedge core_clk) disable iff (!rst_n)
        hw_set[0] |=> flag[0])
        else $error("hardware set lost against clear");
endmodule

// *** rtl/pie_vector_ram.sv ***
`timescale 1ns/1ps
module pie_vector_ram #(
    parameter int DEPTH = 96,
    parameter int AW    = 7,
    parameter int WW    = 16
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_idx,
    input  wire logic          wr_hi,
    input  wire logic [WW-1:0] wr_data,
    input  wire logic          rd_en,
    input  wire logic [AW-1:0] rd_idx,
    output logic    [2*WW-1:0] rd_data
);
    // no reset on the array: software loads every entry before use
    logic [2*WW-1:0] mem [DEPTH];

    always_ff @(posedge core_clk) begin
        if (wr_en && wr_hi) begin
            mem[wr_idx][WW +: WW] <= wr_data;
        end else if (wr_en) begin
            mem[wr_idx][0 +: WW] <= wr_data;
        end
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= '0;
        end else if (rd_en) begin
            rd_data <= mem[rd_idx];
        end
    end
endmodule

// *** sim/pie_cpu_model.sv ***
`timescale 1ns/1ps
module pie_cpu_model (
    input  wire logic              core_clk,
    input  wire pie_pkg::pie_vec_s cpu_vec,
    output pie_pkg::pie_ack_s      cpu_ack
);
    import pie_pkg::*;

    initial cpu_ack = '{valid: 1'b0, line: 4'hA};

    // one ack, then wait for the vector; stall delays the ack
    task automatic service(input logic [3:0] line, input int stall,
                           output pie_vec_s ans, output int lat);
        repeat (stall + 1) begin
            @(posedge core_clk);
            #1;
        end
        cpu_ack = '{valid: 1'b1, line: line};
        @(posedge core_clk);
        #1;
        // stale line scrambled so a late decode shows up
        cpu_ack = '{valid: 1'b0, line: ~line};
        lat = 0;
        ans = '0;
        while (lat < FETCH_MAX_CYC && ans.valid !== 1'b1) begin
            @(posedge core_clk);
            #1;
            lat++;
            ans = cpu_vec;
        end
    endtask
endmodule

// *** sim/testbench.sv ***
`timescale 1ns/1ps
module testbench;
    import pie_pkg::*;
    logic                  core_clk;
    logic                  rst_n;
    logic [NUM_POS-1:0]    src;
    logic [DMA_CH-1:0]     dma;
    logic [ADC_EV-1:0]     adc;
    logic [IPC_IRQ-1:0]    ipc;
    logic [1:0]            fpu;
    logic [2:0]            byp;
    wire  [2:0]            byp_o;
    pie_grp_wr_s           fw;
    pie_grp_wr_s           ew;
    pie_vec_wr_s           vw;
    pie_ack_s              ack;
    logic [LINE_W-1:0]     rd_line;
    logic [NUM_GROUPS-1:0] lines;
    pie_vec_s              vec;
    logic [GROUP_W-1:0]    rdf;
    logic [GROUP_W-1:0]    rde;
    logic [31:0]           rnd;
    bit   [NUM_POS-1:0]    m_flag;
    bit   [NUM_POS-1:0]    m_en;
    int                    m_vec[NUM_POS];
    int                    err_count;
    int                    total_checks;
    int                    seed;

    pie_expander DUT (
        .core_clk(core_clk), .rst_n(rst_n), .periph_src(src),
        .dma_channel_irq(dma), .adc_event(adc), .interprocessor_irq(ipc),
        .fpu_overflow_event(fpu[0]), .fpu_underflow_event(fpu[1]),
        .timer_one_irq(byp[0]), .timer_two_irq(byp[1]),
        .direct_nmi_request(byp[2]), .flag_wr(fw), .enable_wr(ew),
        .vec_wr(vw), .cpu_ack(ack), .rd_line(rd_line),
        .cpu_group_lines(lines), .cpu_vec(vec), .rd_flag(rdf),
        .rd_enable(rde), .timer_one_line(byp_o[0]),
        .timer_two_line(byp_o[1]), .nmi_line(byp_o[2])
    );
    pie_cpu_model cpu (.core_clk(core_clk), .cpu_vec(vec), .cpu_ack(ack));

    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end

    task automatic tick();
        @(posedge core_clk);
        #1;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
        cmp({24'h0, g}, {24'h0, e});
    endtask
    task automatic chk_lines(input logic [11:0] g, input logic [11:0] e);
        cmp({20'h0, g}, {20'h0, e});
    endtask
    task automatic chk_vec(input logic [31:0] g, input logic [31:0] e);
        cmp(g, e);
    endtask

    function automatic logic [11:0] m_lines();
        logic [11:0] r;
        for (int g = 0; g < NUM_GROUPS; g++) begin
            r[g] = |(m_flag[g*8+:8] & m_en[g*8+:8]);
        end
        return r;
    endfunction

    // whole-byte writes only while sources are quiet, so none is lost
    task automatic grp_wr(input bit is_flag, input int line,
                          input logic [7:0] d);
        tick();
        if (is_flag) fw = '{1'b1, line[3:0], d};
        else ew = '{1'b1, line[3:0], d};
        tick();
        fw.valid = 1'b0;
        ew.valid = 1'b0;
        if (line < 1 || line > 12) return;
        if (is_flag) m_flag[(line-1)*8+:8] = d;
        else m_en[(line-1)*8+:8] = d;
    endtask

    task automatic chk_all();
        for (int g = 1; g <= NUM_GROUPS; g++) begin
            rd_line = g[3:0];
            tick();
            tick();
            chk_byte(rdf, m_flag[(g-1)*8+:8]);
            chk_byte(rde, m_en[(g-1)*8+:8]);
        end
        chk_lines(lines, m_lines());
    endtask

    task automatic wr_vec(input logic [15:0] a, input logic [15:0] d);
        int i;
        tick();
        vw = '{1'b1, a, d};
        tick();
        vw.valid = 1'b0;
        i = (int'(a) - 'h0D40) / 2;
        if (a < 16'h0D40 || a > 16'h0DFF) return;
        if (a[0]) m_vec[i][31:16] = d;
        else m_vec[i][15:0] = d;
    endtask

    task automatic hw_pulse();
        bit [NUM_POS-1:0] ovr;
        tick();
        src = {$random(seed), $random(seed), $random(seed)};
        rnd = $random(seed);
        {dma, adc, ipc, fpu} = rnd[19:0];
        tick();
        ovr = '0;
        ovr[6*8+:6] = '1;
        ovr[9*8+:8] = '1;
        ovr[10*8+:4] = '1;
        ovr[11*8+6+:2] = '1;
        m_flag |= src & WIRED_MASK & ~ovr;
        m_flag[6*8+:6] |= dma;
        m_flag[9*8+:8] |= adc;
        m_flag[10*8+:4] |= ipc;
        m_flag[11*8+6+:2] |= fpu;
        src = '0;
        {dma, adc, ipc, fpu} = '0;
    endtask

    task automatic serve(input int line, input int stall);
        int g;
        int p;
        int lat;
        pie_vec_s a;
        g = (line - 1) * 8;
        p = -1;
        for (int i = 7; i >= 0; i--) begin
            if (m_flag[g+i] && m_en[g+i]) p = i;
        end
        cpu.service(line[3:0], stall, a, lat);
        // taken at the edge after the ack is raised, answer two edges later
        chk_lines(lat[11:0], 12'h002);
        chk_byte({a.hit, a.line, (p < 0) ? 3'h0 : a.pos},
                 {p >= 0, line[3:0], (p < 0) ? 3'h0 : p[2:0]});
        chk_vec(a.vector, (p < 0) ? 32'h0 : m_vec[g+p]);
        if (p >= 0) m_flag[g+p] = 1'b0;
    endtask

    task automatic end_of_test();
        $display("checks=%0d errors=%0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        #1000000;
        err_count++;
        end_of_test();
    end

    initial begin
        seed = 32'hf8f94c77;
        err_count = 0;
        total_checks = 0;
        src = '0;
        {dma, adc, ipc, fpu} = '0;
        byp = '0;
        fw = '0;
        ew = '0;
        vw = '0;
        rd_line = 4'h1;
        rst_n = 1'b0;
        m_flag = '0;
        m_en = '0;
        repeat (2) @(posedge core_clk);
        #1;
        chk_lines(lines, 12'h000);
        rst_n = 1'b1;
        for (int i = 0; i < 2 * NUM_POS; i++) begin
            rnd = $random(seed);
            wr_vec(16'h0D40 + i[15:0], rnd[15:0]);
        end
        wr_vec(16'h0D3F, 16'hFFFF);
        wr_vec(16'h0E00, 16'hFFFF);
        grp_wr(1, 0, 8'hFF);
        grp_wr(1, 13, 8'hFF);
        for (int g = 1; g <= NUM_GROUPS; g++) begin
            rnd = $random(seed);
            grp_wr(0, g, rnd[7:0]);
            grp_wr(1, g, rnd[15:8]);
        end
        chk_all();
        rd_line = 4'hD;
        tick();
        tick();
        chk_byte(rdf, 8'h00);
        // stall 0 is a prompt ack, larger stalls a slow one
        for (int r = 0; r < 3; r++) begin
            for (int g = 1; g <= NUM_GROUPS; g++) serve(g, r);
        end
        chk_all();
        for (int g = 1; g <= NUM_GROUPS; g++) begin
            grp_wr(1, g, 8'h00);
            grp_wr(0, g, 8'hFF);
        end
        repeat (4) hw_pulse();
        chk_all();
        for (int g = 1; g <= NUM_GROUPS; g++) serve(g, 0);
        chk_all();
        for (int g = 1; g <= NUM_GROUPS; g++) grp_wr(0, g, 8'h00);
        chk_all();
        serve(12, 1);
        // reserved position of a quiet group used as a software interrupt
        grp_wr(0, 12, 8'h04);
        grp_wr(1, 12, 8'h04);
        chk_all();
        serve(12, 0);
        chk_all();
        repeat (16) begin
            rnd = $random(seed);
            byp = rnd[2:0];
            tick();
            chk_byte({5'h0, byp_o}, {5'h0, byp});
        end
        rst_n = 1'b0;
        tick();
        rst_n = 1'b1;
        m_flag = '0;
        m_en = '0;
        chk_all();
        end_of_test();
    end
endmodule
